// File: hdl/cbu_branch_unit.sv
// Conditional branch unit: architectural registers, outcome and interrupt
`default_nettype none

module cbu_branch_unit
  import cbu_pkg::*;
(
  input  wire logic        i_clk,            // Core clock
  input  wire logic        i_rst_n,          // Asynchronous reset, active low
  input  wire logic        i_instr_valid,    // Instruction presented this cycle
  input  wire logic [31:0] i_instr,          // Instruction word
  input  wire logic [31:0] i_instr_addr,     // Its address
  input  wire logic [3:0]  i_addr,           // Register word address
  input  wire logic [31:0] i_wdata,          // Register write data
  input  wire logic        i_wr,             // Register write strobe
  input  wire logic        i_rd,             // Register read strobe
  output logic      [31:0] o_rdata,          // Read data, cycle after strobe
  output logic             o_br_valid,       // Branch resolved, one cycle
  output logic             o_br_taken,       // Redirect fetch
  output logic      [31:0] o_br_target,      // Branch target
  output logic             o_br_invalid,     // Invalid form detected
  output logic      [1:0]  o_br_hint,        // a/t likelihood hint
  output logic      [1:0]  o_br_target_hint, // target_hint of count form
  output logic             o_irq             // Level interrupt
);

  // Complete state of the unit
  typedef struct packed {
    logic [31:0]          lcnt;        // loop_counter
    logic [31:0]          lr;          // Link register
    logic [31:0]          cr;          // Condition register
    logic [1:0]           mode;        // Encoding rule set
    logic [CBU_EVT_W-1:0] status;      // Sticky events
    logic [CBU_EVT_W-1:0] irq_en;      // Interrupt enables
    logic [31:0]          last_target; // Last resolved target
    logic [31:0]          rdata;       // Read data
    logic                 br_valid;
    logic                 br_taken;
    logic [31:0]          br_target;
    logic                 br_invalid;
    logic [1:0]           br_hint;
    logic [1:0]           br_thint;
    logic                 irq;
  } cbu_state_s;

  cbu_state_s st_reg;  // Registered state
  cbu_state_s st_next; // Next state

  logic        d_is_branch; // Decoder outputs
  logic        d_invalid;
  logic        d_taken;
  logic [31:0] d_target;
  logic        d_dec_cnt;
  logic [31:0] d_cnt_next;
  logic        d_link;
  logic [31:0] d_link_addr;
  logic [1:0]  d_hint;
  logic [1:0]  d_thint;
  logic        branch_go; // Branch acted on this cycle

  // Pure combinational evaluation against the current registers
  cbu_decode u_decode (
    .i_instr      (i_instr),
    .i_instr_addr (i_instr_addr),
    .i_lcnt       (st_reg.lcnt),
    .i_cr         (st_reg.cr),
    .i_mode       (st_reg.mode),
    .o_is_branch  (d_is_branch),
    .o_invalid    (d_invalid),
    .o_taken      (d_taken),
    .o_target     (d_target),
    .o_dec_cnt    (d_dec_cnt),
    .o_cnt_next   (d_cnt_next),
    .o_link       (d_link),
    .o_link_addr  (d_link_addr),
    .o_hint       (d_hint),
    .o_thint      (d_thint)
  );

  assign branch_go = i_instr_valid & d_is_branch;

  // Next-state logic: software access first, then branch effects
  always_comb begin
    st_next = st_reg;
    st_next.br_valid = 1'b0; // One-cycle pulse
    st_next.rdata    = 32'h0;
    // Read returns the state before this cycle's updates
    if (i_rd) begin
      unique case (i_addr)
        CBU_A_LOOP_CNT: st_next.rdata = st_reg.lcnt;
        CBU_A_LINK:     st_next.rdata = st_reg.lr;
        CBU_A_COND_REG: st_next.rdata = st_reg.cr;
        CBU_A_MODE:     st_next.rdata = {30'h0, st_reg.mode};
        CBU_A_STATUS:   st_next.rdata = {29'h0, st_reg.status};
        CBU_A_IRQ_EN:   st_next.rdata = {29'h0, st_reg.irq_en};
        CBU_A_LAST_TGT: st_next.rdata = st_reg.last_target;
        default:        st_next.rdata = 32'h0; // Unmapped and clear register
      endcase
    end
    // Software writes; status is read-only
    if (i_wr) begin
      unique case (i_addr)
        CBU_A_LOOP_CNT: st_next.lcnt   = i_wdata;
        CBU_A_LINK:     st_next.lr     = i_wdata;
        CBU_A_COND_REG: st_next.cr     = i_wdata;
        CBU_A_MODE:     st_next.mode   = i_wdata[1:0];
        CBU_A_IRQ_EN:   st_next.irq_en = i_wdata[CBU_EVT_W-1:0];
        CBU_A_IRQ_CLR:  st_next.status = st_reg.status & ~i_wdata[CBU_EVT_W-1:0];
        default: begin
          // Read-only or unmapped: write ignored
        end
      endcase
    end
    // Branch effects override a software write in the same cycle
    if (branch_go) begin
      st_next.br_valid   = 1'b1;
      st_next.br_invalid = d_invalid;
      st_next.br_taken   = d_taken;
      st_next.br_target  = d_target;
      st_next.br_hint    = d_hint;
      st_next.br_thint   = d_thint;
      if (d_dec_cnt) begin
        st_next.lcnt = d_cnt_next;
      end
      if (d_link) begin
        st_next.lr = d_link_addr;
      end
      if (!d_invalid) begin
        st_next.last_target = d_target;
      end
      // Set wins over a clear in the same cycle
      if (d_invalid) begin
        st_next.status[CBU_EVT_INVALID] = 1'b1;
      end else if (d_taken) begin
        st_next.status[CBU_EVT_TAKEN] = 1'b1;
      end else begin
        st_next.status[CBU_EVT_FALL] = 1'b1;
      end
    end
    // Condition register is written only by software, never here
    st_next.irq = |(st_next.status & st_next.irq_en);
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state flip-flops
  assign o_rdata          = st_reg.rdata;
  assign o_br_valid       = st_reg.br_valid;
  assign o_br_taken       = st_reg.br_taken;
  assign o_br_target      = st_reg.br_target;
  assign o_br_invalid     = st_reg.br_invalid;
  assign o_br_hint        = st_reg.br_hint;
  assign o_br_target_hint = st_reg.br_thint;
  assign o_irq            = st_reg.irq;

  // Helper terms for the checks below, decoded independently
  logic        chk_cond;  // Displacement form presented
  logic        chk_cnt;   // Count form presented
  logic [31:0] chk_disp;  // Expected displacement
  logic        chk_crbit; // Expected condition bit
  logic        chk_legacy;
  logic        chk_new;

  assign chk_cond   = i_instr_valid && (i_instr[31:26] == CBU_OPC_COND);
  assign chk_cnt    = i_instr_valid && (i_instr[31:26] == CBU_OPC_XL) && (i_instr[10:1] == CBU_XO_TO_CNT);
  assign chk_disp   = {{16{i_instr[15]}}, i_instr[15:2], 2'b00};
  assign chk_crbit  = st_reg.cr[5'h1F - i_instr[20:16]];
  assign chk_legacy = (st_reg.mode == CBU_MODE_LEGACY);
  assign chk_new    = (st_reg.mode == CBU_MODE_NEW);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Relative target adds the instruction address
  a_rel_target: assert property (chk_cond && !i_instr[1] |=>
    o_br_target == $past(i_instr_addr) + $past(chk_disp))
    else $error("relative target wrong");

  // Absolute target is the displacement alone
  a_abs_target: assert property (chk_cond && i_instr[1] |=>
    o_br_target == $past(chk_disp))
    else $error("absolute target wrong");

  // Only the two branch forms produce a result pulse
  a_decode_forms: assert property (i_instr_valid |=>
    o_br_valid == $past(chk_cond || chk_cnt))
    else $error("branch form decode wrong");

  // Condition register untouched unless software writes it
  a_cr_untouched: assert property (!(i_wr && i_addr == CBU_A_COND_REG) |=>
    $stable(st_reg.cr))
    else $error("condition register changed by branch");

  // Link register holds the return address
  a_link_save: assert property ((chk_cond || chk_cnt) && i_instr[0] |=>
    o_br_invalid || st_reg.lr == $past(i_instr_addr) + CBU_INSTR_BYTES)
    else $error("link register not saved");

  // Decrementing codes count down by exactly one
  a_cnt_decrement: assert property (chk_cond && !i_instr[23] |=>
    o_br_invalid || st_reg.lcnt == $past(st_reg.lcnt) - 32'h1)
    else $error("counter not decremented");

  // Non-decrementing codes leave the counter alone
  a_cnt_hold: assert property (chk_cond && i_instr[23] && !(i_wr && i_addr == CBU_A_LOOP_CNT) |=>
    $stable(st_reg.lcnt))
    else $error("counter changed unexpectedly");

  // Branch-always codes are taken
  a_always_taken: assert property (chk_cond && chk_legacy && i_instr[25] && i_instr[23] |=>
    o_br_valid && o_br_taken)
    else $error("branch always not taken");

  // Count-only codes test the decremented value
  a_count_only: assert property (chk_cond && chk_legacy && i_instr[25] && !i_instr[23] && !i_instr[22] |=>
    o_br_taken == ($past(st_reg.lcnt) != 32'h1))
    else $error("count-only outcome wrong");

  // A set must-be-zero bit is flagged in the newer mode
  a_zbit_invalid: assert property (chk_cond && chk_new && i_instr[25] && i_instr[23]
    && (i_instr[24] || i_instr[22] || i_instr[21]) |=> o_br_invalid && !o_br_taken)
    else $error("invalid form not flagged");

  // Legacy mode never flags the displacement form
  a_legacy_accept: assert property (chk_cond && chk_legacy |=> !o_br_invalid)
    else $error("legacy form rejected");

  // Condition-only codes follow the selected bit, hint bits ignored
  a_cond_select: assert property (chk_cond && !i_instr[25] && i_instr[23] && !chk_new |=>
    o_br_invalid || o_br_taken == ($past(chk_crbit) == $past(i_instr[24])))
    else $error("condition bit test wrong");

  // Count form takes its target from the counter, hint reported
  a_cnt_target: assert property (chk_cnt |=>
    o_br_target == {$past(st_reg.lcnt[31:2]), 2'b00} && o_br_target_hint == $past(i_instr[12:11]))
    else $error("count form target wrong");

  // Newer-mode hint bits are reported as given
  a_hint_report: assert property (chk_cond && chk_new && !i_instr[25] && i_instr[23] |=>
    o_br_hint == $past(i_instr[22:21]))
    else $error("hint bits not reported");

  // Main scenarios
  c_rel_taken: cover property (chk_cond && !i_instr[1] ##1 o_br_taken);
  c_cnt_taken: cover property (chk_cnt ##1 o_br_taken);
  c_invalid:   cover property (chk_cond && chk_new ##1 o_br_invalid);
  c_irq:       cover property (o_br_valid ##1 o_irq);

endmodule

`default_nettype wire

// File: hdl/cbu_decode.sv
// Combinational decode and outcome evaluation of the conditional branches
`default_nettype none

module cbu_decode
  import cbu_pkg::*;
(
  input  wire logic [31:0] i_instr,      // Instruction word
  input  wire logic [31:0] i_instr_addr, // Address of the instruction
  input  wire logic [31:0] i_lcnt,       // Current loop_counter
  input  wire logic [31:0] i_cr,         // Current condition register
  input  wire logic [1:0]  i_mode,       // Encoding rule set
  output logic             o_is_branch,  // Recognised branch form
  output logic             o_invalid,    // Invalid branch_options form
  output logic             o_taken,      // Branch outcome
  output logic [31:0]      o_target,     // Target address
  output logic             o_dec_cnt,    // Counter must be updated
  output logic [31:0]      o_cnt_next,   // Decremented counter
  output logic             o_link,       // Link register must be written
  output logic [31:0]      o_link_addr,  // Return address
  output logic [1:0]       o_hint,       // a/t likelihood hint
  output logic [1:0]       o_thint       // target_hint of count form
);

  logic [4:0]  branch_options; // Big-endian bit 0 sits in [4]
  logic [4:0]  cond_select;    // Condition register bit index
  logic [31:0] disp;           // Sign-extended displacement_field
  logic        is_cond;        // Displacement form
  logic        is_cnt;         // Count register form
  logic        cr_bit;         // Selected condition bit
  logic        cnt_ok;         // Counter test passes
  logic        cond_ok;        // Condition test passes
  logic        zbad;           // A must-be-zero bit is set
  logic        b0, b1, b2, b3, b4;

  // Whole decode in one process so the outcome terms stay together
  always_comb begin
    branch_options = i_instr[CBU_OPT_HI:CBU_OPT_LO];
    cond_select    = i_instr[CBU_CSEL_HI:CBU_CSEL_LO];
    {b0, b1, b2, b3, b4} = branch_options;
    disp = {{16{i_instr[CBU_DISP_HI]}}, i_instr[CBU_DISP_HI:CBU_DISP_LO], 2'b00};
    is_cond = (i_instr[CBU_OPC_HI:CBU_OPC_LO] == CBU_OPC_COND);
    is_cnt  = (i_instr[CBU_OPC_HI:CBU_OPC_LO] == CBU_OPC_XL)
           && (i_instr[CBU_XO_HI:CBU_XO_LO] == CBU_XO_TO_CNT);
    o_is_branch = is_cond | is_cnt;
    cr_bit = i_cr[5'h1F - cond_select];
    o_cnt_next = i_lcnt - 32'h1;
    // b2 clear decrements; b3 picks zero or nonzero as the pass case
    cnt_ok  = b2 | ((o_cnt_next == 32'h0) == b3);
    // b0 set ignores the condition; b1 picks true or false
    cond_ok = b0 | (cr_bit == b1);
    zbad = 1'b0;
    o_hint = 2'b00;
    unique case (i_mode)
      CBU_MODE_LEGACY: zbad = 1'b0;
      CBU_MODE_PRE: begin
        // Older layout: z positions differ, y is a pure hint
        unique case ({b0, b2})
          2'b00:   zbad = 1'b0;
          2'b01:   zbad = b3;
          2'b10:   zbad = b1;
          default: zbad = b1 | b3 | b4;
        endcase
      end
      default: begin
        // Newer layout; reserved mode code falls here as well
        unique case ({b0, b2})
          2'b00: zbad = b4;
          2'b01: begin
            zbad   = 1'b0;
            o_hint = {b3, b4};
          end
          2'b10: begin
            zbad   = 1'b0;
            o_hint = {b1, b4};
          end
          default: zbad = b1 | b3 | b4;
        endcase
      end
    endcase
    // Outside legacy mode the counter cannot both feed the target and count down
    if (is_cnt && !b2 && (i_mode != CBU_MODE_LEGACY)) begin
      zbad = 1'b1;
    end
    o_invalid = o_is_branch & zbad;
    // Hints are only reported, never fed into the outcome
    o_taken = o_is_branch & ~o_invalid & cnt_ok & cond_ok;
    if (is_cnt) begin
      o_target = {i_lcnt[31:2], 2'b00};
    end else if (i_instr[CBU_ABS_BIT]) begin
      o_target = disp;
    end else begin
      o_target = i_instr_addr + disp;
    end
    o_dec_cnt   = o_is_branch & ~o_invalid & ~b2;
    o_link      = o_is_branch & ~o_invalid & i_instr[CBU_LINK_BIT];
    o_link_addr = i_instr_addr + CBU_INSTR_BYTES;
    o_thint     = is_cnt ? i_instr[CBU_THINT_HI:CBU_THINT_LO] : 2'b00;
  end

endmodule

`default_nettype wire

// File: hdl/cbu_pkg.sv
// Constants, field layout and register map of the conditional branch unit
//
// Overview of operation
// - Relative target: sign-extended displacement plus address
// - Absolute target: sign-extended displacement used directly
// - Opcode 16, bit 30 absolute, bit 31 link
// - Never touch exception register or field 0
// - Link save writes next instruction address
// - Decrement counter, test zero state and condition
// - No decrement, test condition only; 1z1zz always
// - Decrement counter, ignore condition, test zero
// - Newer mode: any z bit set is invalid
// - Old y hint never changes the outcome
// - Legacy mode accepts any z and y
// - a/t hint bits never alter the result
// - Condition bit chosen by bits 11 to 15
// - Count form: opcode 19, extended 528, hint bits
// - Count form target: counter high 30 bits
`default_nettype none

package cbu_pkg;

  // Instruction word layout, big-endian bit 0 is the MSB here
  localparam int CBU_OPC_HI   = 31;
  localparam int CBU_OPC_LO   = 26;
  localparam int CBU_OPT_HI   = 25;
  localparam int CBU_OPT_LO   = 21;
  localparam int CBU_CSEL_HI  = 20;
  localparam int CBU_CSEL_LO  = 16;
  localparam int CBU_DISP_HI  = 15;
  localparam int CBU_DISP_LO  = 2;
  localparam int CBU_THINT_HI = 12;
  localparam int CBU_THINT_LO = 11;
  localparam int CBU_XO_HI    = 10;
  localparam int CBU_XO_LO    = 1;
  localparam int CBU_ABS_BIT  = 1;
  localparam int CBU_LINK_BIT = 0;

  // Opcode values
  localparam logic [5:0]  CBU_OPC_COND  = 6'h10;
  localparam logic [5:0]  CBU_OPC_XL    = 6'h13;
  localparam logic [9:0]  CBU_XO_TO_CNT = 10'h210;
  localparam logic [31:0] CBU_INSTR_BYTES = 32'h4;

  // Register word addresses
  localparam logic [3:0] CBU_A_LOOP_CNT  = 4'h0;
  localparam logic [3:0] CBU_A_LINK      = 4'h1;
  localparam logic [3:0] CBU_A_COND_REG  = 4'h2;
  localparam logic [3:0] CBU_A_MODE      = 4'h3;
  localparam logic [3:0] CBU_A_STATUS    = 4'h4;
  localparam logic [3:0] CBU_A_IRQ_EN    = 4'h5;
  localparam logic [3:0] CBU_A_IRQ_CLR   = 4'h6;
  localparam logic [3:0] CBU_A_LAST_TGT  = 4'h7;

  // Reset values
  localparam logic [31:0] CBU_RST_WORD = 32'h0;
  localparam logic [2:0]  CBU_RST_EVT  = 3'h0;

  // Event bit positions in status, enable and clear
  localparam int CBU_EVT_TAKEN   = 0;
  localparam int CBU_EVT_FALL    = 1;
  localparam int CBU_EVT_INVALID = 2;
  localparam int CBU_EVT_W       = 3;

  // Branch-option encoding rule set; code 3 behaves as the newer set
  typedef enum logic [1:0] {
    CBU_MODE_NEW    = 2'b00,
    CBU_MODE_PRE    = 2'b01,
    CBU_MODE_LEGACY = 2'b10
  } cbu_mode_e;

endpackage

`default_nettype wire

// File: tb/tb.sv
// Self-checking testbench of the conditional branch unit
`default_nettype none

module tb
  import cbu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Stimulus and observed signals
  logic        i_clk;
  logic        i_rst_n;
  logic        i_instr_valid;
  logic [31:0] i_instr;
  logic [31:0] i_instr_addr;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_br_valid;
  logic        o_br_taken;
  logic [31:0] o_br_target;
  logic        o_br_invalid;
  logic [1:0]  o_br_hint;
  logic [1:0]  o_br_target_hint;
  logic        o_irq;
  int          miscompares;  // Mismatches seen
  int          check_count;  // Comparisons made

  // One row of the branch-option table
  typedef struct packed {
    logic [4:0]  opt;
    logic [4:0]  sel;
    logic [31:0] cnt;
    logic        tk;
    logic [31:0] cnt_n;
  } cbu_case_s;
  cbu_case_s cases [16];

  cbu_branch_unit uut (
    .i_clk            (i_clk),
    .i_rst_n          (i_rst_n),
    .i_instr_valid    (i_instr_valid),
    .i_instr          (i_instr),
    .i_instr_addr     (i_instr_addr),
    .i_addr           (i_addr),
    .i_wdata          (i_wdata),
    .i_wr             (i_wr),
    .i_rd             (i_rd),
    .o_rdata          (o_rdata),
    .o_br_valid       (o_br_valid),
    .o_br_taken       (o_br_taken),
    .o_br_target      (o_br_target),
    .o_br_invalid     (o_br_invalid),
    .o_br_hint        (o_br_hint),
    .o_br_target_hint (o_br_target_hint),
    .o_irq            (o_irq)
  );

  // 100 ns core clock
  always #50 i_clk = ~i_clk;

  // Closing verdict, shared by the main sequence and the watchdog
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Word compare; case inequality so an unknown never matches
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Single-bit flag compare
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr   <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read strobe, data taken in the following cycle only
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(nm, exp, o_rdata);
  endtask

  // Present one instruction; returns inside the result cycle
  task automatic exec(input logic [31:0] ins, input logic [31:0] pc);
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr       <= ins;
    i_instr_addr  <= pc;
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
  endtask

  // Displacement form encoder
  function automatic logic [31:0] enc_cond(logic [4:0] opt, logic [4:0] sel, logic [13:0] dsp, logic abs_sel,
                                           logic lnk);
    return {CBU_OPC_COND, opt, sel, dsp, abs_sel, lnk};
  endfunction

  // Count form encoder; extended opcode is a parameter to test a miss
  function automatic logic [31:0] bcnt(logic [4:0] opt, logic [1:0] th, logic [9:0] xo, logic lnk);
    return {CBU_OPC_XL, opt, 5'h00, 3'h0, th, xo, lnk};
  endfunction

  // Short branch check: valid pulse, invalid flag, outcome
  task automatic chk_br(input logic inv, input logic tk);
    chk_bit("br_valid", 1'b1, o_br_valid);
    chk_bit("br_invalid", inv, o_br_invalid);
    chk_bit("br_taken", tk, o_br_taken);
  endtask

  // Watchdog: fires after 20000 cycles; the tests need well under that
  initial begin
    #(20000 * 100);
    miscompares++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    i_instr_valid = 1'b0;
    i_instr = 32'h0;
    i_instr_addr = 32'h0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    miscompares = 0;
    check_count = 0;
    // Condition register 8000_0001: index 0 and 31 true, index 1 false
    cases = '{
      '{5'b00000, 5'd1, 32'h3, 1'b1, 32'h2}, '{5'b00000, 5'd1, 32'h1, 1'b0, 32'h0},
      '{5'b00010, 5'd1, 32'h1, 1'b1, 32'h0}, '{5'b00010, 5'd0, 32'h1, 1'b0, 32'h0},
      '{5'b01000, 5'd0, 32'h3, 1'b1, 32'h2}, '{5'b01000, 5'd1, 32'h3, 1'b0, 32'h2},
      '{5'b01010, 5'd0, 32'h1, 1'b1, 32'h0}, '{5'b00100, 5'd1, 32'h5, 1'b1, 32'h5},
      '{5'b00100, 5'd0, 32'h5, 1'b0, 32'h5}, '{5'b01100, 5'd0, 32'h5, 1'b1, 32'h5},
      '{5'b10000, 5'd1, 32'h3, 1'b1, 32'h2}, '{5'b10010, 5'd1, 32'h2, 1'b0, 32'h1},
      '{5'b10010, 5'd0, 32'h1, 1'b1, 32'h0}, '{5'b10100, 5'd1, 32'h5, 1'b1, 32'h5},
      '{5'b01100, 5'd31, 32'h5, 1'b1, 32'h5}, '{5'b00100, 5'd31, 32'h5, 1'b0, 32'h5}};
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // All registers clear after reset; unmapped word and status write ignored
    for (int a = 0; a < 9; a++) begin
      rd_chk("reset_reg", a[3:0], CBU_RST_WORD);
    end
    wr(CBU_A_STATUS, 32'h7);
    rd_chk("status_ro", CBU_A_STATUS, 32'h0);
    wr(CBU_A_COND_REG, 32'h8000_0001);
    // Every branch-option form with z, a and t clear against the counter and condition
    for (int k = 0; k < 16; k++) begin
      wr(CBU_A_LOOP_CNT, cases[k].cnt);
      exec(enc_cond(cases[k].opt, cases[k].sel, 14'h0010, 1'b0, 1'b0), 32'h0000_2000);
      chk_br(1'b0, cases[k].tk);
      chk("rel_target", 32'h0000_2040, o_br_target);
      rd_chk("loop_counter", CBU_A_LOOP_CNT, cases[k].cnt_n);
    end
    // Four forms, negative displacement, link only with link_save
    for (int f = 0; f < 4; f++) begin
      wr(CBU_A_LINK, 32'h0);
      exec(enc_cond(5'b10100, 5'd0, 14'h2000, f[0], f[1]), 32'h0000_1000);
      chk_br(1'b0, 1'b1);
      chk("form_target", f[0] ? 32'hFFFF_8000 : 32'hFFFF_9000, o_br_target);
      rd_chk("link", CBU_A_LINK, f[1] ? 32'h0000_1004 : 32'h0);
    end
    // Newer rules: a set z bit is refused and leaves the counter alone
    wr(CBU_A_LOOP_CNT, 32'h3);
    exec(enc_cond(5'b00001, 5'd1, 14'h0010, 1'b0, 1'b1), 32'h0);
    chk_br(1'b1, 1'b0);
    exec(enc_cond(5'b11100, 5'd1, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk_br(1'b1, 1'b0);
    rd_chk("ctr_after_invalid", CBU_A_LOOP_CNT, 32'h3);
    // a/t hints reported, outcome still follows the condition
    exec(enc_cond(5'b01111, 5'd0, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk_br(1'b0, 1'b1);
    chk("hint", 32'h3, {30'h0, o_br_hint});
    exec(enc_cond(5'b00111, 5'd0, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk_br(1'b0, 1'b0);
    exec(enc_cond(5'b01110, 5'd0, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk("hint", 32'h2, {30'h0, o_br_hint});
    // Older rules: y changes nothing, z position still checked
    wr(CBU_A_MODE, 32'h1);
    wr(CBU_A_LOOP_CNT, 32'h3);
    exec(enc_cond(5'b00001, 5'd1, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk_br(1'b0, 1'b1);
    chk("old_hint", 32'h0, {30'h0, o_br_hint});
    exec(enc_cond(5'b00110, 5'd1, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk_br(1'b1, 1'b0);
    // Legacy rules accept any z and y
    wr(CBU_A_MODE, 32'h2);
    exec(enc_cond(5'b00001, 5'd1, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk_br(1'b0, 1'b1);
    exec(enc_cond(5'b11111, 5'd1, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk_br(1'b0, 1'b1);
    rd_chk("legacy_ctr", CBU_A_LOOP_CNT, 32'h1);
    wr(CBU_A_MODE, 32'h0);
    // Count form: low counter bits dropped, hint and link kept
    wr(CBU_A_LOOP_CNT, 32'h0000_1237);
    exec(bcnt(5'b10100, 2'b11, CBU_XO_TO_CNT, 1'b1), 32'h0000_3000);
    chk_br(1'b0, 1'b1);
    chk("cnt_target", 32'h0000_1234, o_br_target);
    chk("target_hint", 32'h3, {30'h0, o_br_target_hint});
    rd_chk("cnt_link", CBU_A_LINK, 32'h0000_3004);
    rd_chk("last_target", CBU_A_LAST_TGT, 32'h0000_1234);
    // Wrong extended opcode and other primary opcode give no pulse
    exec(bcnt(5'b10100, 2'b00, 10'h20F, 1'b0), 32'h0);
    chk_bit("no_branch", 1'b0, o_br_valid);
    exec({6'h12, 26'h0}, 32'h0);
    chk_bit("no_branch", 1'b0, o_br_valid);
    rd_chk("cond_reg_kept", CBU_A_COND_REG, 32'h8000_0001);
    // Interrupt: masked event, enabled event, clear
    wr(CBU_A_IRQ_CLR, 32'h7);
    wr(CBU_A_IRQ_EN, 32'h1);
    exec(enc_cond(5'b00100, 5'd0, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk_bit("irq_masked", 1'b0, o_irq);
    rd_chk("status_fall", CBU_A_STATUS, 32'h2);
    exec(enc_cond(5'b10100, 5'd0, 14'h0010, 1'b0, 1'b0), 32'h0);
    chk_bit("irq_set", 1'b1, o_irq);
    wr(CBU_A_IRQ_CLR, 32'h1);
    repeat (2) @(posedge i_clk);
    #1;
    chk_bit("irq_clear", 1'b0, o_irq);
    rd_chk("status_left", CBU_A_STATUS, 32'h2);
    report_and_stop();
  end

endmodule

`default_nettype wire
